/* core/power_mode_defs.vh */
// Summary of operation
// - With all supplies present and enable low, enter Disabled.
// - With all supplies present and enable high, enter Reset.
// - In Reset, leave when the reset pin goes high, to Idle or Bootloader.
// - Leaving Reset, boot-select low gives Bootloader, high gives Idle.
// - Idle moves to Active or Bootloader only on the matching host command.
// - Reset pin low forces Reset from any mode and holds it there.
// - Enable low forces Disabled from any mode; Disabled draws least current.
// - No start-up without a 24 MHz reference clock present.
// - Transmit carrier is the tunable oscillator divided by four.
// - Forward and reverse power detectors are digitised by the auxiliary converter.
// - Forward power feeds closed-loop control of the fine transmit gain.
// - Selected general-purpose outputs steer an external antenna switch.
// - Mode-change commands arrive over a serial interface where the device is slave; the code takes them as cmd_i with a cmd_valid_i strobe.
`ifndef POWER_MODE_DEFS_VH
`define POWER_MODE_DEFS_VH
`define MODE_DISABLED 3'h0
`define MODE_RESET 3'h1
`define MODE_IDLE 3'h2
`define MODE_BOOT 3'h3
`define MODE_ACTIVE 3'h4
`define CMD_NONE 2'h0
`define CMD_ACTIVE 2'h1
`define CMD_BOOT 2'h2
`define CMD_IDLE 2'h3
`define REF_FREQ_KHZ 24000
`define SYS_FREQ_KHZ 100000
`define REF_WINDOW_CYC 64
`define REF_EDGES_MIN 12
`define REF_EDGES_MAX 18
`define CARRIER_DIV 4
`define GAIN_RESET 8'h80
`define GAIN_STEP 8'h01
`endif

/* core/ref_clock_monitor.v */
`timescale 1ns/100ps
`include "power_mode_defs.vh"
// Counts rising edges of the synchronised reference clock over a fixed window of system
// cycles; reports present when the count fits a 24 MHz clock at the 100 MHz system rate.
module ref_clock_monitor #(
  parameter WINDOW = `REF_WINDOW_CYC
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire ref_sync_i,
  output reg present_o
);
  reg [7:0] win_reg;
  reg [7:0] edges_reg;
  reg last_reg;
  wire rise;

  assign rise = ref_sync_i & ~last_reg;

  // A 24 MHz clock sampled at 100 MHz gives about 15 edges per 64 cycles; a margin
  // absorbs sampling jitter, and a missing or wrong clock drops presence at window end.
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      win_reg <= 8'h00;
      edges_reg <= 8'h00;
      last_reg <= 1'b0;
      present_o <= 1'b0;
    end else begin
      last_reg <= ref_sync_i;
      if (win_reg == WINDOW - 1) begin
        win_reg <= 8'h00;
        edges_reg <= 8'h00;
        present_o <= (edges_reg >= `REF_EDGES_MIN) && (edges_reg <= `REF_EDGES_MAX);
      end else begin
        win_reg <= win_reg + 8'h01;
        if (rise) begin
          edges_reg <= edges_reg + 8'h01;
        end
      end
    end
  end
endmodule // ref_clock_monitor

/* core/reader_power_mode_sequencer.v */
`timescale 1ns/100ps
`include "power_mode_defs.vh"
// Power-mode sequencer with carrier divider, power-control loop and antenna select.
module reader_power_mode_sequencer #(
  parameter GPIO_W = 4,
  parameter ADC_W = 10
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire supplies_ok_i,
  input wire enable_i,
  input wire reset_n_i,
  input wire boot_sel_n_i,
  input wire reference_clock_input_i,
  input wire vco_clk_i,
  input wire cmd_valid_i,
  input wire [1:0] cmd_i,
  input wire [ADC_W-1:0] fwd_target_i,
  input wire [GPIO_W-1:0] ant_sel_i,
  input wire ant_sel_valid_i,
  input wire adc_done_i,
  input wire [ADC_W-1:0] adc_data_i,
  output reg [2:0] mode_o,
  output wire low_power_o,
  output reg adc_start_o,
  output reg adc_chan_o,
  output reg [ADC_W-1:0] fwd_power_o,
  output reg [ADC_W-1:0] rev_power_o,
  output reg [7:0] fine_gain_o,
  output reg [GPIO_W-1:0] gpio_o,
  output reg gpio_oe_o,
  output reg carrier_o
);
  // Two-flop synchronisers for every pin from outside the clock domain.
  reg [1:0] sup_s_reg;
  reg [1:0] en_s_reg;
  reg [1:0] rst_s_reg;
  reg [1:0] boot_s_reg;
  reg [1:0] ref_s_reg;
  wire sup_ok;
  wire en_ok;
  wire rst_hi;
  wire boot_lo;
  wire ref_ok;
  reg [2:0] mode_next;
  reg [1:0] div_reg;
  reg [1:0] vco_rst_reg;
  reg adc_busy_reg;

  // True when a command strobe carries the wanted code in this cycle.
  // Both the Idle exits and the return to Idle use it, so the decode lives in one place.
  function cmd_hit;
    input valid;
    input [1:0] code;
    input [1:0] want;
    begin
      cmd_hit = valid && (code == want);
    end
  endfunction

  // True in the modes where the antenna switch may be steered.
  // Disabled, Reset and Bootloader leave the switch pins released to save current.
  function mode_drives;
    input [2:0] mode;
    begin
      mode_drives = (mode == `MODE_ACTIVE) || (mode == `MODE_IDLE);
    end
  endfunction

  // Next fine gain from one forward-power sample.
  // The gain saturates at both ends rather than wrapping, since a wrap would
  // swing the transmit power from maximum to minimum in a single step.
  function [7:0] gain_step;
    input [7:0] gain;
    input [ADC_W-1:0] sample;
    input [ADC_W-1:0] target;
    begin
      gain_step = gain;
      if (sample < target && gain != 8'hFF) begin
        gain_step = gain + `GAIN_STEP;
      end else if (sample > target && gain != 8'h00) begin
        gain_step = gain - `GAIN_STEP;
      end
    end
  endfunction

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      sup_s_reg <= 2'h0;
      en_s_reg <= 2'h0;
      rst_s_reg <= 2'h0;
      boot_s_reg <= 2'h3;
      ref_s_reg <= 2'h0;
    end else begin
      sup_s_reg <= {sup_s_reg[0], supplies_ok_i};
      en_s_reg <= {en_s_reg[0], enable_i};
      rst_s_reg <= {rst_s_reg[0], reset_n_i};
      boot_s_reg <= {boot_s_reg[0], boot_sel_n_i};
      ref_s_reg <= {ref_s_reg[0], reference_clock_input_i};
    end
  end

  assign sup_ok = sup_s_reg[1];
  assign en_ok = en_s_reg[1];
  assign rst_hi = rst_s_reg[1];
  assign boot_lo = ~boot_s_reg[1];

  // Reference presence gates start-up since there is no internal clock source.
  ref_clock_monitor #(
    .WINDOW(`REF_WINDOW_CYC)
  ) i_ref_clock_monitor (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .ref_sync_i(ref_s_reg[1]),
    .present_o(ref_ok)
  );

  // Mode selection; enable low outranks reset, which outranks commands.
  always @* begin
    mode_next = mode_o;
    if (!sup_ok || !en_ok) begin
      mode_next = `MODE_DISABLED;
    end else if (!rst_hi) begin
      mode_next = `MODE_RESET;
    end else begin
      case (mode_o)
        `MODE_DISABLED: begin
          mode_next = `MODE_RESET;
        end
        `MODE_RESET: begin
          // Boot-select is only looked at here, on the way out of Reset.
          if (ref_ok) begin
            mode_next = boot_lo ? `MODE_BOOT : `MODE_IDLE;
          end
        end
        `MODE_IDLE: begin
          // Only a command moves the device from Idle to Active or Bootloader; pins alone never do.
          if (cmd_hit(cmd_valid_i, cmd_i, `CMD_ACTIVE)) begin
            mode_next = `MODE_ACTIVE;
          end else if (cmd_hit(cmd_valid_i, cmd_i, `CMD_BOOT)) begin
            mode_next = `MODE_BOOT;
          end
        end
        `MODE_ACTIVE, `MODE_BOOT: begin
          // The way back to Idle is a command as well, so the host stays in charge.
          if (cmd_hit(cmd_valid_i, cmd_i, `CMD_IDLE)) begin
            mode_next = `MODE_IDLE;
          end
        end
        default: begin
          mode_next = `MODE_RESET;
        end
      endcase
    end
  end

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      mode_o <= `MODE_DISABLED;
    end else begin
      mode_o <= mode_next;
    end
  end

  assign low_power_o = (mode_o == `MODE_DISABLED);

  // The system reset is brought into the oscillator domain through two flops.
  // Without it the divider would power up unknown and never leave that state.
  always @(posedge vco_clk_i) begin
    vco_rst_reg <= {vco_rst_reg[0], srst_i};
  end

  // Carrier divide-by-four; the oscillator runs in its own domain and only this
  // counter and the reset synchroniser live there, so nothing crosses back into the system clock.
  always @(posedge vco_clk_i) begin
    if (vco_rst_reg[1]) begin
      div_reg <= 2'h0;
      carrier_o <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      carrier_o <= div_reg[1];
    end
  end

  // Auxiliary converter sequencing alternates forward and reverse detectors in Active.
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      adc_start_o <= 1'b0;
      adc_chan_o <= 1'b0;
      adc_busy_reg <= 1'b0;
      fwd_power_o <= {ADC_W{1'b0}};
      rev_power_o <= {ADC_W{1'b0}};
      fine_gain_o <= `GAIN_RESET;
    end else begin
      adc_start_o <= 1'b0;
      if (mode_o != `MODE_ACTIVE) begin
        adc_busy_reg <= 1'b0;
      end else if (!adc_busy_reg) begin
        adc_start_o <= 1'b1;
        adc_busy_reg <= 1'b1;
      end else if (adc_done_i) begin
        adc_busy_reg <= 1'b0;
        adc_chan_o <= ~adc_chan_o;
        if (!adc_chan_o) begin
          fwd_power_o <= adc_data_i;
          // One gain step per sample keeps the loop slow and stable, at the cost of settling time.
          fine_gain_o <= gain_step(fine_gain_o, adc_data_i, fwd_target_i);
        end else begin
          rev_power_o <= adc_data_i;
        end
      end
    end
  end

  // Antenna switch outputs drive only while the device is Idle or Active.
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      gpio_o <= {GPIO_W{1'b0}};
      gpio_oe_o <= 1'b0;
    end else begin
      gpio_oe_o <= mode_drives(mode_o);
      if (ant_sel_valid_i) begin
        gpio_o <= ant_sel_i;
      end
    end
  end
endmodule // reader_power_mode_sequencer

/* tb/host_model.sv */
`timescale 1ns/100ps
// Host side: a 24 MHz reference that stands low when absent, and the boot strap.
module host_model (
  input wire ref_on_i,
  input wire boot_req_i,
  output reg ref_o,
  output wire boot_sel_n_o
);
  // No edges at all while off, so start-up must wait.
  initial begin
    ref_o = 1'b0;
    forever #20.8 ref_o = ref_on_i & ~ref_o;
  end
  // Strap low asks for the loader.
  assign boot_sel_n_o = ~boot_req_i;
endmodule // host_model

/* tb/reader_power_mode_sequencer_chk.sv */
`timescale 1ns/100ps
// Mode checks; pin effects land three cycles late, so pins must be calm first.
module reader_power_mode_sequencer_chk (
  input wire ref_clk_i,
  input wire srst_i,
  input wire supplies_ok_i,
  input wire enable_i,
  input wire reset_n_i,
  input wire cmd_valid_i,
  input wire [1:0] cmd_i,
  input wire [2:0] mode_o,
  input wire low_power_o,
  input wire [7:0] fine_gain_o
);
  reg [1:0] ok_reg;
  wire ok = supplies_ok_i & enable_i & reset_n_i;
  wire calm = ok & (&ok_reg);
  // History of the pins so no override is in flight.
  always @(posedge ref_clk_i) ok_reg <= {ok_reg[0], ok};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  property p_dis; (supplies_ok_i && !enable_i)[*5] |-> mode_o == 3'h0; endproperty
  a_dis: assert property (p_dis) else $error("not disabled");
  property p_rst; (supplies_ok_i && enable_i && !reset_n_i)[*5] |-> mode_o == 3'h1; endproperty
  a_rst: assert property (p_rst) else $error("not reset");
  property p_lp; low_power_o == (mode_o == 3'h0); endproperty
  a_lp: assert property (p_lp) else $error("low power");
  property p_act; calm && mode_o == 3'h2 && cmd_valid_i && cmd_i == 2'h1 |=> mode_o == 3'h4; endproperty
  a_act: assert property (p_act) else $error("no active");
  property p_bld; calm && mode_o == 3'h2 && cmd_valid_i && cmd_i == 2'h2 |=> mode_o == 3'h3; endproperty
  a_bld: assert property (p_bld) else $error("no loader");
  property p_hold; calm && mode_o == 3'h2 && !cmd_valid_i |=> mode_o == 3'h2; endproperty
  a_hold: assert property (p_hold) else $error("idle left");
  property p_from; mode_o == 3'h4 && $past(mode_o) != 3'h4 |-> $past(mode_o) == 3'h2; endproperty
  a_from: assert property (p_from) else $error("bad entry");
  property p_gain; !$stable(fine_gain_o) |-> fine_gain_o == $past(fine_gain_o) + 8'h01
    || fine_gain_o == $past(fine_gain_o) - 8'h01; endproperty
  a_gain: assert property (p_gain) else $error("gain step");
endmodule // reader_power_mode_sequencer_chk
bind reader_power_mode_sequencer reader_power_mode_sequencer_chk i_chk (.ref_clk_i(ref_clk_i),
  .srst_i(srst_i), .supplies_ok_i(supplies_ok_i), .enable_i(enable_i), .reset_n_i(reset_n_i),
  .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .mode_o(mode_o), .low_power_o(low_power_o),
  .fine_gain_o(fine_gain_o));

/* tb/test_reader_power_mode_sequencer.sv */
`timescale 1ns/100ps
// Drives pins at the falling edge and judges modes and outputs.
module test_reader_power_mode_sequencer;
  reg clk = 1'b0, srst = 1'b1, sup = 1'b0, en = 1'b0, rn = 1'b0, vco = 1'b0, cv = 1'b0;
  reg ron = 1'b0, brq = 1'b0, ad = 1'b0, av = 1'b0;
  reg [1:0] cmd = 2'h0;
  reg [9:0] adat = 10'h000;
  reg [3:0] ant = 4'h0;
  reg [7:0] s;
  wire rw, bs, lp, ast, ach, oe, car;
  wire [2:0] mode;
  wire [9:0] fwd, rev;
  wire [7:0] gain;
  wire [3:0] gpio;
  integer n_fail = 0, n_tests = 0, k;
  initial forever #5 clk = ~clk;
  initial forever #0.7 vco = ~vco;
  host_model i_host_model (.ref_on_i(ron), .boot_req_i(brq), .ref_o(rw), .boot_sel_n_o(bs));
  reader_power_mode_sequencer i_reader_power_mode_sequencer (.ref_clk_i(clk), .srst_i(srst),
    .supplies_ok_i(sup), .enable_i(en), .reset_n_i(rn), .boot_sel_n_i(bs),
    .reference_clock_input_i(rw), .vco_clk_i(vco), .cmd_valid_i(cv), .cmd_i(cmd),
    .fwd_target_i(10'h200), .ant_sel_i(ant), .ant_sel_valid_i(av), .adc_done_i(ad),
    .adc_data_i(adat), .mode_o(mode), .low_power_o(lp), .adc_start_o(ast), .adc_chan_o(ach),
    .fwd_power_o(fwd), .rev_power_o(rev), .fine_gain_o(gain), .gpio_o(gpio),
    .gpio_oe_o(oe), .carrier_o(car));
  task chk(input [9:0] got, input [9:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Bounded waits; a wait that runs out fails its compare, and in wm also ends the run.
  task wm(input [2:0] m);
    begin
      for (k = 0; mode !== m && k < 300; k = k + 1) @(negedge clk);
      chk(mode, m);
      if (k == 300) test_done;
    end
  endtask
  task send(input [1:0] c);
    begin cv = 1'b1; cmd = c; @(negedge clk); cv = 1'b0; @(negedge clk); end
  endtask
  task adc(input ch, input [9:0] d);
    begin
      for (k = 0; ast !== 1'b1 && k < 300; k = k + 1) @(negedge clk);
      chk({ast, ach}, {1'b1, ch});
      adat = d; ad = 1'b1; @(negedge clk); ad = 1'b0;
    end
  endtask
  task t_power_up;
    begin
      sup = 1'b1; rn = 1'b1; ron = 1'b1; wm(3'h0); chk({lp, oe}, 2'h2);
      ron = 1'b0; en = 1'b1; wm(3'h1); repeat (200) @(negedge clk); chk(mode, 3'h1);
      brq = 1'b1; ron = 1'b1; wm(3'h3); brq = 1'b0; repeat (9) @(negedge clk);
      chk(mode, 3'h3);
    end
  endtask
  task t_reset_idle;
    begin
      rn = 1'b0; wm(3'h1); repeat (90) @(negedge clk); chk(mode, 3'h1);
      rn = 1'b1; wm(3'h2);
      ant = 4'hA; av = 1'b1; @(negedge clk); av = 1'b0; repeat (3) @(negedge clk);
      chk({oe, gpio}, 5'h1A);
    end
  endtask
  task t_active;
    begin
      send(2'h1); wm(3'h4);
      adc(1'b0, 10'h100); chk(fwd, 10'h100); chk(gain, 8'h81);
      adc(1'b1, 10'h0AA); chk(rev, 10'h0AA);
      send(2'h3); wm(3'h2); send(2'h2); wm(3'h3); send(2'h3); wm(3'h2);
      en = 1'b0; wm(3'h0);
    end
  endtask
  // The carrier must invert every second oscillator edge.
  task t_carrier;
    begin
      repeat (8) begin @(posedge vco); #0.1 s = {s[6:0], car}; end
      chk(s[7:2] ^ s[5:0], 6'h3F);
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    t_power_up;
    t_reset_idle;
    t_active;
    t_carrier;
    test_done;
  end
endmodule // test_reader_power_mode_sequencer
